/* File: verilog/periodic_timer_pkg.sv */
// package: register map, field positions, reset values, encodings for the periodic timer
package periodic_timer_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte registers, plain port)
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL0 = 4'h0;
    localparam logic [3:0] OFS_CTRL1 = 4'h1;
    localparam logic [3:0] OFS_COUNT_LOW = 4'h2;
    localparam logic [3:0] OFS_COUNT_HIGH = 4'h3;
    localparam logic [3:0] OFS_COMPARE_A_LOW = 4'h4;
    localparam logic [3:0] OFS_COMPARE_A_HIGH = 4'h5;
    localparam logic [3:0] OFS_PERIOD_VALUE_LOW = 4'h6;
    localparam logic [3:0] OFS_PERIOD_VALUE_HIGH = 4'h7;
    localparam logic [3:0] OFS_FLAGS = 4'h8;
    // ------------------------------------------------------------------
    // control 0 fields
    // ------------------------------------------------------------------
    localparam int CTRL0_PAUSE = 7;
    localparam int CTRL0_CLKSEL_MSB = 6;
    localparam int CTRL0_CLKSEL_LSB = 4;
    localparam int CTRL0_COUNTER_ON = 3;
    // ------------------------------------------------------------------
    // control 1 fields (timer_control_one)
    // ------------------------------------------------------------------
    localparam int CTRL1_MODE_MSB = 7;
    localparam int CTRL1_MODE_LSB = 6;
    localparam int CTRL1_PIN_ACTION_MSB = 5;
    localparam int CTRL1_PIN_ACTION_LSB = 4;
    localparam int CTRL1_OUTPUT_LEVEL = 3;
    localparam int CTRL1_INVERT = 2;
    localparam int CTRL1_CLEAR_SOURCE = 0;
    // ------------------------------------------------------------------
    // flag register fields (write one to clear)
    // ------------------------------------------------------------------
    localparam int FLAG_MATCH_A = 0;
    localparam int FLAG_MATCH_P = 1;
    // ------------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [9:0] RESET_WORD = 10'h000;
    localparam logic [9:0] COUNT_MAX = 10'h3FF;
    localparam logic [9:0] COUNT_ONE = 10'h001;
    localparam logic [1:0] RESET_TWO = 2'h0;
    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_PWM_PULSE = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] PWM_INACTIVE = 2'h0;
    localparam logic [1:0] PWM_ACTIVE = 2'h1;
    localparam logic [1:0] PWM_WAVE = 2'h2;
    localparam logic [1:0] PWM_SINGLE = 2'h3;
    localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CLK_SYS = 3'h1;
    localparam logic [2:0] CLK_H_DIV16 = 3'h2;
    localparam logic [2:0] CLK_H_DIV64 = 3'h3;
    localparam logic [2:0] CLK_EXT_RISE = 3'h6;
    localparam logic [2:0] CLK_EXT_FALL = 3'h7;
    localparam logic [5:0] PRESCALE_DIV4_MASK = 6'h03;
    localparam logic [5:0] PRESCALE_DIV16_MASK = 6'h0F;
    localparam logic [5:0] PRESCALE_DIV64_MASK = 6'h3F;
    localparam logic [5:0] PRESCALE_ZERO = 6'h00;
endpackage

/* File: verilog/periodic_timer.sv */
// periodic timer: 10-bit counter, comparators a and p, four operating modes
// ----------------------------------------------------------------------
// Functional notes
// - mode 00 compare, 11 timer, 10 pwm (action 00-10) or single pulse (11)
// - compare mode, clear source low: clear on p match or overflow; both flags
// - compare mode, clear source high: clear on a match; only the a flag
// - compare value a zero: overflow at 3FF, no a flag for it
// - compare mode: pin changes only on a match or counter-on rise, never on p match
// - on a match pin goes high, low, toggles, or holds per pin action
// - compare mode: pin start level from output level bit on counter-on rise
// - timer mode: as compare mode but pin not driven
// - pwm: period value clears counter; 1..1023 counts, zero gives 1024
// - pwm: compare a at or above period gives constant active output
// - pwm: a flag on a match, p flag on p match
// - pwm: output level bit picks polarity, action enables or forces; invert
// - pwm: clear source bit ignored, period comparator always clears
// - pwm counting continues while action forces the pin
// - single pulse: counter-on rise starts counter and pulse leading edge
// - single pulse: external clock pin edge sets counter-on
// - single pulse: a match clears counter-on, ends pulse, raises flag
// - single pulse: counter zeroed only on counter-on rise; period unused
// - counter-on rise zeroes counter, fall freezes it
// - compare mode actions: 00 hold, 01 low, 10 high, 11 toggle
// ----------------------------------------------------------------------
module periodic_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // timer clocks and pins
    input wire logic tick_h,
    input wire logic tick_sub,
    input wire logic ext_timer_clock_pin,
    output logic timer_output_pin,
    output logic timer_output_oe,
    // flag outputs
    output logic match_a_flag,
    output logic match_p_flag
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] compare_a_value;
    logic [9:0] period_compare_value;
    logic [9:0] count;
    logic counter_on_d;
    logic ext_d;
    logic raw_level;
    logic [5:0] pre_sys;
    logic [5:0] pre_h;
    logic sub_d;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    wire logic counter_on = ctrl0[periodic_timer_pkg::CTRL0_COUNTER_ON];
    wire logic pause = ctrl0[periodic_timer_pkg::CTRL0_PAUSE];
    wire logic [2:0] clk_sel =
        ctrl0[periodic_timer_pkg::CTRL0_CLKSEL_MSB:periodic_timer_pkg::CTRL0_CLKSEL_LSB];
    wire logic [1:0] mode =
        ctrl1[periodic_timer_pkg::CTRL1_MODE_MSB:periodic_timer_pkg::CTRL1_MODE_LSB];
    wire logic [1:0] pin_action =
        ctrl1[periodic_timer_pkg::CTRL1_PIN_ACTION_MSB:periodic_timer_pkg::CTRL1_PIN_ACTION_LSB];
    wire logic output_level_ctrl = ctrl1[periodic_timer_pkg::CTRL1_OUTPUT_LEVEL];
    wire logic output_invert = ctrl1[periodic_timer_pkg::CTRL1_INVERT];
    wire logic clear_source_select = ctrl1[periodic_timer_pkg::CTRL1_CLEAR_SOURCE];

    // mode 01 is undefined; it is treated as compare-like with the pin driven
    wire logic is_cmp = (mode == periodic_timer_pkg::MODE_COMPARE);
    wire logic is_tmr = (mode == periodic_timer_pkg::MODE_TIMER);
    wire logic is_pp = (mode == periodic_timer_pkg::MODE_PWM_PULSE);
    wire logic is_single = is_pp && (pin_action == periodic_timer_pkg::PWM_SINGLE);
    wire logic is_pwm = is_pp && !is_single;

    wire logic on_rise = counter_on && !counter_on_d;

    // ------------------------------------------------------------------
    // timer tick selection
    // ------------------------------------------------------------------
    wire logic ext_rise = ext_timer_clock_pin && !ext_d;
    wire logic ext_fall = !ext_timer_clock_pin && ext_d;
    wire logic sub_rise = tick_sub && !sub_d;
    logic tick;
    always_comb begin
        case (clk_sel)
            periodic_timer_pkg::CLK_SYS_DIV4:
                tick = ((pre_sys & periodic_timer_pkg::PRESCALE_DIV4_MASK)
                        == periodic_timer_pkg::PRESCALE_ZERO);
            periodic_timer_pkg::CLK_SYS: tick = 1'b1;
            periodic_timer_pkg::CLK_H_DIV16:
                tick = tick_h && ((pre_h & periodic_timer_pkg::PRESCALE_DIV16_MASK)
                        == periodic_timer_pkg::PRESCALE_ZERO);
            periodic_timer_pkg::CLK_H_DIV64:
                tick = tick_h && ((pre_h & periodic_timer_pkg::PRESCALE_DIV64_MASK)
                        == periodic_timer_pkg::PRESCALE_ZERO);
            periodic_timer_pkg::CLK_EXT_RISE: tick = ext_rise;
            periodic_timer_pkg::CLK_EXT_FALL: tick = ext_fall;
            default: tick = sub_rise;
        endcase
    end

    // single pulse trigger edge follows the selected pin polarity
    wire logic ext_edge = (clk_sel == periodic_timer_pkg::CLK_EXT_FALL) ? ext_fall : ext_rise;

    // ------------------------------------------------------------------
    // counting and comparison
    // ------------------------------------------------------------------
    wire logic running = counter_on && !on_rise && !pause;
    wire logic step = running && tick;
    wire logic [9:0] count_up = count + periodic_timer_pkg::COUNT_ONE;
    // comparisons are made against the freshly advanced count
    wire logic a_eq = step && (count_up == compare_a_value);
    wire logic p_eq = step && (count_up == period_compare_value);
    wire logic at_max = step && (count == periodic_timer_pkg::COUNT_MAX);
    wire logic a_zero = (compare_a_value == periodic_timer_pkg::RESET_WORD);
    wire logic p_zero = (period_compare_value == periodic_timer_pkg::RESET_WORD);
    // a match at zero is the wrap at 3FF and does not count as an a event
    wire logic a_match = a_eq && !a_zero;
    // period zero: the wrap after 3FF acts as the period match (1024 counts)
    wire logic p_match = p_zero ? at_max : p_eq;

    logic clear_now;
    logic set_a;
    logic set_p;
    always_comb begin
        clear_now = 1'b0;
        set_a = 1'b0;
        set_p = 1'b0;
        if (is_single) begin
            set_a = a_match;
        end else if (is_pwm) begin
            clear_now = p_match;
            set_a = a_match;
            set_p = p_match;
        end else if (clear_source_select) begin
            clear_now = a_match;
            set_a = a_match;
        end else begin
            clear_now = p_match;
            set_a = a_match;
            set_p = p_match;
        end
    end

    logic [9:0] next_count;
    always_comb begin
        if (on_rise)
            next_count = periodic_timer_pkg::RESET_WORD;
        else if (clear_now)
            next_count = periodic_timer_pkg::RESET_WORD;
        else if (step)
            next_count = count_up;
        else
            next_count = count;
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    wire logic wr_c0 = wr && hit(addr, periodic_timer_pkg::OFS_CTRL0);
    wire logic wr_c1 = wr && hit(addr, periodic_timer_pkg::OFS_CTRL1);
    wire logic wr_al = wr && hit(addr, periodic_timer_pkg::OFS_COMPARE_A_LOW);
    wire logic wr_ah = wr && hit(addr, periodic_timer_pkg::OFS_COMPARE_A_HIGH);
    wire logic wr_pl = wr && hit(addr, periodic_timer_pkg::OFS_PERIOD_VALUE_LOW);
    wire logic wr_ph = wr && hit(addr, periodic_timer_pkg::OFS_PERIOD_VALUE_HIGH);
    wire logic wr_fl = wr && hit(addr, periodic_timer_pkg::OFS_FLAGS);

    // counter-on bit: software write, then hardware set and clear in single pulse
    logic next_on;
    always_comb begin
        next_on = wr_c0 ? wdata[periodic_timer_pkg::CTRL0_COUNTER_ON] : counter_on;
        if (is_single && ext_edge && !counter_on)
            next_on = 1'b1;
        if (is_single && a_match)
            next_on = 1'b0;
    end

    logic [7:0] next_ctrl0;
    always_comb begin
        next_ctrl0 = wr_c0 ? (wdata & 8'hF8) : ctrl0;
        next_ctrl0[periodic_timer_pkg::CTRL0_COUNTER_ON] = next_on;
    end

    // hardware set wins over a same-cycle write-one clear
    wire logic next_flag_a = set_a || (match_a_flag && !(wr_fl && wdata[0]));
    wire logic next_flag_p = set_p || (match_p_flag && !(wr_fl && wdata[1]));

    // ------------------------------------------------------------------
    // output level
    // ------------------------------------------------------------------
    wire logic pwm_on = (compare_a_value >= period_compare_value && !p_zero) ||
                        (next_count < compare_a_value);
    logic next_level;
    always_comb begin
        next_level = raw_level;
        if (is_cmp || is_tmr || mode == 2'h1) begin
            if (on_rise)
                next_level = output_level_ctrl;
            else if (a_match) begin
                case (pin_action)
                    periodic_timer_pkg::ACT_LOW: next_level = 1'b0;
                    periodic_timer_pkg::ACT_HIGH: next_level = 1'b1;
                    periodic_timer_pkg::ACT_TOGGLE: next_level = !raw_level;
                    default: next_level = raw_level;
                endcase
            end
        end else if (is_single) begin
            // pulse is active exactly while counter-on stays high
            next_level = next_on ? output_level_ctrl : !output_level_ctrl;
        end else begin
            case (pin_action)
                periodic_timer_pkg::PWM_INACTIVE: next_level = !output_level_ctrl;
                periodic_timer_pkg::PWM_ACTIVE: next_level = output_level_ctrl;
                default: next_level = (counter_on && pwm_on) ? output_level_ctrl
                                                           : !output_level_ctrl;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;
    always_comb begin
        case (addr)
            periodic_timer_pkg::OFS_CTRL0: next_rdata = ctrl0;
            periodic_timer_pkg::OFS_CTRL1: next_rdata = ctrl1;
            periodic_timer_pkg::OFS_COUNT_LOW: next_rdata = count[7:0];
            periodic_timer_pkg::OFS_COUNT_HIGH: next_rdata = {6'h00, count[9:8]};
            periodic_timer_pkg::OFS_COMPARE_A_LOW: next_rdata = compare_a_value[7:0];
            periodic_timer_pkg::OFS_COMPARE_A_HIGH:
                next_rdata = {6'h00, compare_a_value[9:8]};
            periodic_timer_pkg::OFS_PERIOD_VALUE_LOW: next_rdata = period_compare_value[7:0];
            periodic_timer_pkg::OFS_PERIOD_VALUE_HIGH:
                next_rdata = {6'h00, period_compare_value[9:8]};
            periodic_timer_pkg::OFS_FLAGS: next_rdata = {6'h00, match_p_flag, match_a_flag};
            default: next_rdata = periodic_timer_pkg::RESET_BYTE;
        endcase
        if (!rd)
            next_rdata = periodic_timer_pkg::RESET_BYTE;
    end

    // ------------------------------------------------------------------
    // flip-flops: control and compare registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl0 <= periodic_timer_pkg::RESET_BYTE;
        end else begin
            ctrl0 <= next_ctrl0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl1 <= periodic_timer_pkg::RESET_BYTE;
        end else begin
            if (wr_c1)
                ctrl1 <= wdata & 8'hFD;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            compare_a_value <= periodic_timer_pkg::RESET_WORD;
        end else begin
            if (wr_al)
                compare_a_value[7:0] <= wdata;
            if (wr_ah)
                compare_a_value[9:8] <= wdata[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            period_compare_value <= periodic_timer_pkg::RESET_WORD;
        end else begin
            if (wr_pl)
                period_compare_value[7:0] <= wdata;
            if (wr_ph)
                period_compare_value[9:8] <= wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // flip-flops: counter, edge history and prescalers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count <= periodic_timer_pkg::RESET_WORD;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            counter_on_d <= 1'b0;
            ext_d <= 1'b0;
            sub_d <= 1'b0;
        end else begin
            counter_on_d <= counter_on;
            ext_d <= ext_timer_clock_pin;
            sub_d <= tick_sub;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pre_sys <= periodic_timer_pkg::PRESCALE_ZERO;
            pre_h <= periodic_timer_pkg::PRESCALE_ZERO;
        end else begin
            pre_sys <= pre_sys + 6'h01;
            if (tick_h)
                pre_h <= pre_h + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // flip-flops: pin, flags and read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            raw_level <= 1'b0;
        end else begin
            raw_level <= next_level;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else begin
            match_a_flag <= next_flag_a;
            match_p_flag <= next_flag_p;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= periodic_timer_pkg::RESET_BYTE;
        end else begin
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_output_pin <= 1'b0;
            timer_output_oe <= 1'b0;
        end else begin
            // invert applies in every driving mode; timer mode releases the pin
            timer_output_pin <= next_level ^ output_invert;
            timer_output_oe <= !is_tmr;
        end
    end
endmodule

/* File: testbench/periodic_timer_props.sv */
// checker: port-level properties of the periodic timer
module periodic_timer_props (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // pin and flags
    input wire logic timer_output_pin,
    input wire logic timer_output_oe,
    input wire logic match_a_flag,
    input wire logic match_p_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // shadow of the control bits, rebuilt from the write strobe
    // ------------------------------------------------------------------
    logic [7:0] ctrl1_q;
    logic on_q;
    wire c0_wr = wr && addr == periodic_timer_pkg::OFS_CTRL0;
    wire fl_wr = wr && addr == periodic_timer_pkg::OFS_FLAGS;
    wire fa_clr = fl_wr && wdata[periodic_timer_pkg::FLAG_MATCH_A];
    wire fp_clr = fl_wr && wdata[periodic_timer_pkg::FLAG_MATCH_P];
    wire [1:0] mode = ctrl1_q[7:6];
    wire is_cmp = mode == periodic_timer_pkg::MODE_COMPARE;
    wire cm_none = is_cmp && ctrl1_q[5:4] == periodic_timer_pkg::ACT_NONE;
    wire pwm_forced = mode == periodic_timer_pkg::MODE_PWM_PULSE && !ctrl1_q[5];
    wire forced_lvl = (ctrl1_q[4] ? ctrl1_q[3] : !ctrl1_q[3]) ^ ctrl1_q[2];
    wire hi_rd = addr == periodic_timer_pkg::OFS_COMPARE_A_HIGH ||
        addr == periodic_timer_pkg::OFS_PERIOD_VALUE_HIGH;
    // counter_on is only tracked from software; single pulse may clear it alone
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl1_q <= 8'h00;
            on_q <= 1'b0;
        end else if (wr && addr == periodic_timer_pkg::OFS_CTRL1) begin
            ctrl1_q <= wdata;
        end else if (c0_wr) begin
            on_q <= wdata[periodic_timer_pkg::CTRL0_COUNTER_ON];
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_quiet;
        cm_none && !c0_wr;
    endsequence
    property p_pin_hold;
        s_quiet ##1 s_quiet ##1 s_quiet |-> $stable(timer_output_pin);
    endproperty
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    a_high_zero: assert property ($past(rd) && $past(hi_rd) |-> rdata[7:2] == 6'h00)
        else $error("high byte upper bits not zero");
    a_flag_a_clear: assert property ($fell(match_a_flag) |-> $past(fa_clr))
        else $error("a flag dropped without a clear");
    a_flag_p_clear: assert property ($fell(match_p_flag) |-> $past(fp_clr))
        else $error("p flag dropped without a clear");
    a_timer_pin_free: assert property ($stable(ctrl1_q) && mode == 2'h3 |-> !timer_output_oe)
        else $error("pin driven in timer mode");
    a_no_p_flag: assert property ($stable(ctrl1_q) && is_cmp && ctrl1_q[0]
        |-> !$rose(match_p_flag))
        else $error("p flag raised with a-match clearing");
    a_forced_level: assert property ($stable(ctrl1_q) && $past(on_q) && on_q && pwm_forced
        |-> timer_output_pin == forced_lvl)
        else $error("forced pwm level wrong");
    a_pin_hold: assert property (p_pin_hold)
        else $error("pin moved with no pin action");
endmodule

bind periodic_timer periodic_timer_props props_u (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_output_pin(timer_output_pin),
    .timer_output_oe(timer_output_oe), .match_a_flag(match_a_flag),
    .match_p_flag(match_p_flag));

/* File: testbench/test_periodic_timer.sv */
// testbench: register-driven scenarios for the periodic timer
module test_periodic_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, wr, rd, ext_pin, pin, oe, fa, fp;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic [7:0] cm_c1 [5] = '{8'h21, 8'h19, 8'h09, 8'h01, 8'h31};
    logic [7:0] pw_c1 [6] = '{8'hA8, 8'hAD, 8'hA8, 8'h88, 8'h98, 8'hA8};
    int pw_a [6] = '{3, 3, 8, 3, 3, 3};
    int pw_p [6] = '{8, 8, 8, 8, 8, 0};
    int pw_n [6] = '{80, 80, 80, 80, 80, 1024};
    int pw_hi [6] = '{30, 50, 80, 0, 80, 3};
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int hc, fl;
    periodic_timer dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .tick_h(1'b0), .tick_sub(1'b0),
        .ext_timer_clock_pin(ext_pin), .timer_output_pin(pin), .timer_output_oe(oe),
        .match_a_flag(fa), .match_p_flag(fp));
    // ------------------------------------------------------------------
    // access and comparison tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // stop, clear both flags, set the mode, then restart from zero
    task automatic start(input logic [7:0] c1);
        wr_reg(4'h0, 8'h10);
        wr_reg(4'h8, 8'h03);
        wr_reg(4'h1, c1);
        wr_reg(4'h0, 8'h18);
    endtask
    task automatic watch(input int n, output int high, output int flips);
        logic last;
        high = 0;
        flips = 0;
        last = pin;
        repeat (n) begin
            @(posedge clk);
            #1;
            high += (pin === 1'b1);
            flips += (pin !== last);
            last = pin;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        ext_pin = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 4; i < 8; i++) begin
            rd_reg(4'(i), rv);
            check(rv, 8'h00);
            wr_reg(4'(i), 8'hFF);
            rd_reg(4'(i), rv);
            check(rv, i[0] ? 8'h03 : 8'hFF);
        end
        wr_reg(4'h9, 8'hFF);
        rd_reg(4'h9, rv);
        check(rv, 8'h00);
        $display("done: registers");
        wr_reg(4'h5, 8'h00);
        wr_reg(4'h7, 8'h00);
        wr_reg(4'h4, 8'h05);
        wr_reg(4'h6, 8'h02);
        foreach (cm_c1[i]) begin
            start(cm_c1[i]);
            repeat (20) @(posedge clk);
            #1;
            if (cm_c1[i][5:4] != periodic_timer_pkg::ACT_TOGGLE)
                check({7'h00, pin}, {7'h00, cm_c1[i][5:4] == periodic_timer_pkg::ACT_HIGH ||
                    (cm_c1[i][5:4] == periodic_timer_pkg::ACT_NONE && cm_c1[i][3])});
            watch(50, hc, fl);
            check(8'(fl), cm_c1[i][5:4] == periodic_timer_pkg::ACT_TOGGLE ? 8'h0A : 8'h00);
            check({6'h00, fp, fa}, 8'h01);
            check({7'h00, oe}, 8'h01);
        end
        wr_reg(4'h6, 8'h09);
        start(8'h00);
        repeat (30) @(posedge clk);
        #1;
        check({6'h00, fp, fa}, 8'h03);
        $display("done: compare match");
        wr_reg(4'h0, 8'h10);
        wr_reg(4'h1, 8'hC0);
        wr_reg(4'h4, 8'h00);
        wr_reg(4'h6, 8'h00);
        start(8'hC0);
        repeat (1100) @(posedge clk);
        #1;
        check({6'h00, fp, fa}, 8'h02);
        check({7'h00, oe}, 8'h00);
        $display("done: timer counter");
        foreach (pw_c1[i]) begin
            wr_reg(4'h4, 8'(pw_a[i]));
            wr_reg(4'h6, 8'(pw_p[i]));
            start(pw_c1[i]);
            repeat (20) @(posedge clk);
            watch(pw_n[i], hc, fl);
            check(8'(hc), 8'(pw_hi[i]));
            if (pw_a[i] < pw_p[i] || pw_p[i] == 0)
                check({6'h00, fp, fa}, 8'h03);
        end
        $display("done: pwm");
        wr_reg(4'h0, 8'h10);
        wr_reg(4'h8, 8'h03);
        wr_reg(4'h4, 8'h06);
        wr_reg(4'h1, 8'hB8);
        for (int k = 0; k < 2; k++) begin
            if (k == 0)
                ext_pin <= 1'b1;
            else
                wr_reg(4'h0, 8'h18);
            watch(40, hc, fl);
            check({7'h00, hc >= 5 && hc <= 7}, 8'h01);
            rd_reg(4'h0, rv);
            check(rv & 8'h08, 8'h00);
            rd_reg(4'h2, rv);
            check(rv, 8'h06);
        end
        check({7'h00, fa}, 8'h01);
        $display("done: single pulse");
        print_verdict();
    end
endmodule
